// >>> bench/testbench.sv
// self-checking bench for the wake-up and status block
// assumes zero-wait apb answers; slow and rtc sources come from the model
`timescale 1ns/1ps
`default_nettype none
module testbench
  import wake_status_pkg::*;
;
  localparam int unsigned DBC_A = 8;
  localparam int unsigned DBC_B = 16;
  logic pclk;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] wake_pin = 16'hfffa;
  logic bo = 1'b0;
  logic md = 1'b0;
  logic mre = 1'b0;
  logic mml = 1'b0;
  logic xtal = 1'b0;
  wire logic [31:0] prdata;
  wire logic pready;
  wire logic pslverr;
  wire logic slow;
  wire logic rtc;
  wire logic wake;
  wire logic bclr;
  wire logic bblk;
  int fail_count = 0;
  int check_count = 0;
  int wakes = 0;
  wake_source_model u_src (.pclk(pclk), .slow_clock(slow), .rtc_output_tick(rtc));
  supply_wakeup_status_logic #(.DBC_4096(DBC_A), .DBC_32768(DBC_B)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .slow_clock(slow), .rtc_output_tick(rtc), .wake_pin(wake_pin),
    .brownout_out(bo), .monitor_detect(md), .monitor_reset_enable(mre),
    .monitor_measure_low(mml), .crystal_selected(xtal), .core_wakeup(wake),
    .backup_storage_clear_low(bclr), .backup_storage_write_block(bblk)
  );
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) if (wake === 1'b1) wakes++;
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask : rd
  // counts source rises until the wake pulse; a hang shows as a wrong count
  task automatic count_to_wake(input logic use_rtc, output int n);
    logic p;
    logic s;
    p = use_rtc ? rtc : slow;
    n = 0;
    repeat (8000) begin
      @(posedge pclk);
      if (wake === 1'b1) break;
      s = use_rtc ? rtc : slow;
      if (s && !p) n++;
      p = s;
    end
  endtask : count_to_wake
  task automatic regs_and_protect();
    logic [31:0] r;
    logic e;
    rd(SYSCTL_WRITE_PROTECT_ADDR, r);
    chk(r, {31'h0, WRITE_PROTECT_RESET});
    rd(WAKE_INPUT_CONFIG_ADDR, r);
    chk(r, WAKE_INPUT_CONFIG_RESET);
    wr(WAKE_INPUT_CONFIG_ADDR, 32'h0004000c);
    wr(SYSCTL_WRITE_PROTECT_ADDR, {24'h123456, 8'h01});
    rd(SYSCTL_WRITE_PROTECT_ADDR, r);
    chk(r, 32'h0);
    wr(SYSCTL_WRITE_PROTECT_ADDR, {WRITE_PROTECT_KEY, 8'h01});
    rd(SYSCTL_WRITE_PROTECT_ADDR, r);
    chk(r, 32'h1);
    wr(WAKE_INPUT_CONFIG_ADDR, 32'hffffffff);
    rd(WAKE_INPUT_CONFIG_ADDR, r);
    chk(r, 32'h0004000c);
    wr(SYSCTL_WRITE_PROTECT_ADDR, 32'h0);
    rd(SYSCTL_WRITE_PROTECT_ADDR, r);
    chk(r, 32'h1);
    wr(SYSCTL_WRITE_PROTECT_ADDR, {WRITE_PROTECT_KEY, 8'h00});
    rd(SYSCTL_WRITE_PROTECT_ADDR, r);
    chk(r, 32'h0);
    apb(1'b0, 32'h400e1500, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, SUPPLY_EVENT_STATUS_ADDR, 32'hffffffff, r, e);
    chk({31'h0, e}, 32'h1);
  endtask : regs_and_protect
  task automatic pin_wake();
    logic [31:0] r;
    int n;
    n = wakes;
    wake_pin[4] <= 1'b0;
    repeat (4) @(posedge slow);
    chk(wakes - n, 0);
    // step the pin off the slow edge so the counted rises match the ticks
    @(posedge pclk);
    wake_pin[3] <= 1'b0;
    count_to_wake(1'b0, n);
    chk(n, 1);
    rd(SUPPLY_EVENT_STATUS_ADDR, r);
    chk(r & 32'h001c0002, 32'h00080002);
    rd(SUPPLY_EVENT_STATUS_ADDR, r);
    chk(r & 32'h2, 32'h2);
    repeat (3) @(posedge slow);
    rd(SUPPLY_EVENT_STATUS_ADDR, r);
    chk(r & 32'h001c0002, 32'h0);
    wake_pin[3] <= 1'b1;
    wake_pin[4] <= 1'b1;
  endtask : pin_wake
  task automatic debounce_codes();
    int unsigned exp_n [6] = '{WAKE_DBC_IMMEDIATE, WAKE_DBC_3, WAKE_DBC_32,
                               WAKE_DBC_512, DBC_A, DBC_B};
    int n;
    for (int c = 0; c < 6; c++) begin
      wr(WAKE_MODE_ADDR, 32'(c) << WAKE_DBC_LSB);
      wake_pin[2] <= 1'b0;
      repeat (3) @(posedge slow);
      @(posedge pclk);
      wake_pin[2] <= 1'b1;
      count_to_wake(1'b0, n);
      chk(n, exp_n[c]);
    end
  endtask : debounce_codes
  task automatic monitor_flags();
    logic [31:0] r;
    wr(WAKE_MODE_ADDR, 32'h2);
    mre <= 1'b1;
    mml <= 1'b1;
    xtal <= 1'b1;
    md <= 1'b1;
    bo <= 1'b1;
    repeat (4) @(posedge slow);
    rd(SUPPLY_EVENT_STATUS_ADDR, r);
    chk(r & 32'hfc, 32'hfc);
    md <= 1'b0;
    mml <= 1'b0;
    xtal <= 1'b0;
    repeat (3) @(posedge slow);
    rd(SUPPLY_EVENT_STATUS_ADDR, r);
    chk(r & 32'hfc, 32'h0);
  endtask : monitor_flags
  task automatic low_power_wake();
    logic [31:0] r;
    int n;
    wr(WAKE_INPUT_CONFIG_ADDR, 32'h0005000c);
    wr(WAKE_MODE_ADDR, 32'h000150a0);
    @(posedge rtc);
    @(posedge pclk);
    wake_pin[0] <= 1'b1;
    count_to_wake(1'b1, n);
    chk(n, 2);
    @(posedge pclk);
    chk({31'h0, bblk}, 32'h1);
    rd(SUPPLY_EVENT_STATUS_ADDR, r);
    chk(r & 32'h6000, 32'h2000);
    wake_pin[0] <= 1'b0;
    repeat (3) @(posedge slow);
    chk({31'h0, bblk}, 32'h0);
  endtask : low_power_wake
  task automatic tally_and_finish();
    if (fail_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    regs_and_protect();
    pin_wake();
    debounce_codes();
    monitor_flags();
    low_power_wake();
    tally_and_finish();
  end
  initial begin
    repeat (40000) @(posedge pclk);
    fail_count++;
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire

// >>> bench/wake_source_model.sv
// free-running slow clock and rtc tick sources facing the wake-up block
// assumes pclk at 40 MHz; both sources are derived from it and never stop
`timescale 1ns/1ps
`default_nettype none
module wake_source_model #(
  parameter int unsigned SLOW_HALF = 4,
  parameter int unsigned RTC_HALF = 8
) (
  // reference
  input wire logic pclk,
  // sources
  output logic slow_clock,
  output logic rtc_output_tick
);
  int unsigned slow_cnt = 0;
  int unsigned rtc_cnt = 0;
  logic slow_q = 1'b0;
  logic rtc_q = 1'b0;
  // half period of four pclk keeps the block's synchroniser margin
  always @(posedge pclk) begin
    slow_cnt <= (slow_cnt == SLOW_HALF - 1) ? 0 : slow_cnt + 1;
    if (slow_cnt == SLOW_HALF - 1) slow_q <= ~slow_q;
  end
  always @(posedge pclk) begin
    rtc_cnt <= (rtc_cnt == RTC_HALF - 1) ? 0 : rtc_cnt + 1;
    if (rtc_cnt == RTC_HALF - 1) rtc_q <= ~rtc_q;
  end
  assign slow_clock = slow_q;
  assign rtc_output_tick = rtc_q;
endmodule : wake_source_model
`default_nettype wire

// >>> bench/wake_status_checker.sv
// concurrent checks on the ports of the wake-up and status block
// assumes a single pclk domain; attached by the bind at the foot
`timescale 1ns/1ps
`default_nettype none
module wake_status_checker
  import wake_status_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // levels and outputs
  input wire logic crystal_selected,
  input wire logic core_wakeup,
  input wire logic backup_storage_clear_low,
  input wire logic backup_storage_write_block
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic rd_any = psel && penable && !pwrite;
  wire logic rd_st = rd_any && paddr == SUPPLY_EVENT_STATUS_ADDR;
  logic [7:0] since_rd_q;
  logic [7:0] xtal_age_q;
  logic xtal_q;
  // saturating ages: the block only drops after a read, crystal must settle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_rd_q <= 8'hff;
      xtal_age_q <= 8'h00;
      xtal_q <= 1'b0;
    end else begin
      since_rd_q <= rd_st ? 8'h00 : since_rd_q + {7'h0, since_rd_q != 8'hff};
      xtal_age_q <= (crystal_selected != xtal_q) ? 8'h00 :
                    xtal_age_q + {7'h0, xtal_age_q != 8'hff};
      xtal_q <= crystal_selected;
    end
  end
  property p_key_zero;
    rd_any && paddr == SYSCTL_WRITE_PROTECT_ADDR |-> prdata[31:1] == 31'h0;
  endproperty
  a_key_zero: assert property (p_key_zero) else $error("key field read nonzero");
  property p_status_ro;
    psel && penable && pwrite && paddr == SUPPLY_EVENT_STATUS_ADDR |-> pslverr;
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status write not refused");
  property p_status_rsv;
    rd_st |-> prdata[15] == 1'b0 && prdata[12:8] == 5'h0 && prdata[0] == 1'b0;
  endproperty
  a_status_rsv: assert property (p_status_rsv) else $error("status spare bit set");
  property p_crystal;
    rd_st && xtal_age_q > 8'h18 |-> prdata[7] == crystal_selected;
  endproperty
  a_crystal: assert property (p_crystal) else $error("source bit wrong");
  property p_wake_pulse;
    core_wakeup |=> !core_wakeup;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake not a pulse");
  property p_clr_pulse;
    backup_storage_clear_low |=> !backup_storage_clear_low;
  endproperty
  a_clr_pulse: assert property (p_clr_pulse) else $error("clear not a pulse");
  property p_clr_wake;
    backup_storage_clear_low |-> ##[0:1] core_wakeup;
  endproperty
  a_clr_wake: assert property (p_clr_wake) else $error("lp event without wake");
  property p_clr_block;
    $rose(backup_storage_clear_low) |-> ##[0:1] backup_storage_write_block[*2];
  endproperty
  a_clr_block: assert property (p_clr_block) else $error("block not raised");
  property p_block_fall;
    $fell(backup_storage_write_block) |-> since_rd_q < 8'h28;
  endproperty
  a_block_fall: assert property (p_block_fall) else $error("block fell without read");
  c_wake: cover property (core_wakeup);
  c_clr: cover property (backup_storage_clear_low);
  c_flag: cover property (rd_st && prdata[1]);
endmodule : wake_status_checker
bind supply_wakeup_status_logic wake_status_checker u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
  .crystal_selected(crystal_selected), .core_wakeup(core_wakeup),
  .backup_storage_clear_low(backup_storage_clear_low),
  .backup_storage_write_block(backup_storage_write_block)
);
`default_nettype wire

// >>> hdl/level_debouncer.sv
// one debouncer: counts ticks of a continuously active input
// assumes active and tick are on pclk; tick is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module level_debouncer #(
  parameter int unsigned CNT_W = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic tick,
  input wire logic active,
  input wire logic [CNT_W-1:0] limit,
  // result
  output logic fire
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic done_q;
  logic reach;

  assign reach = tick && active && !done_q && (cnt_q + 1'b1 >= limit);
  assign fire = reach;

  always_comb begin
    cnt_d = cnt_q;
    if (!active) begin
      cnt_d = '0;
    end else if (tick && !done_q) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  // one fire per active stretch; input must go inactive to rearm
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      done_q <= active ? (done_q | reach) : 1'b0;
    end
  end

endmodule : level_debouncer
`default_nettype wire

// >>> hdl/supply_wakeup_status_logic.sv
// wake-up debouncing, clear-on-read supply status and keyed write protection
// assumes an apb master on pclk; all monitor and wake pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - period zero recognises input on one edge
// - periods one to five need long activity
// - low-power period zero disables both debouncers
// - low-power count is field plus one
// - protected writes to input config ignored
// - only enabled inputs can wake core via the wake debouncers; pins 0 and 1 also wake it via low-power enable
// - polarity bit picks active level
// - status read clears flags two ticks later
// - pin wake-up sets wake flag
// - monitor wake-up sets monitor wake flag
// - brownout flag only on rising edge
// - monitor reset sets monitor reset flag
// - any monitor detection sets detect flag
// - monitor output bit shows last measurement
// - source bit shows crystal or rc
// - separate low-power wake flags per pin
// - snapshot enabled active inputs at pin wake trigger
// - protect bit changes only with key
// - wrong key aborts; key reads zero
// - low-power enable connects pin to debouncer
// - low-power event clears lower backup half
// - tamper blocks backup writes until flags cleared
module supply_wakeup_status_logic
  import wake_status_pkg::*;
#(
  parameter int unsigned DBC_4096 = WAKE_DBC_4096,
  parameter int unsigned DBC_32768 = WAKE_DBC_32768
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // asynchronous pins
  input wire logic slow_clock,
  input wire logic rtc_output_tick,
  input wire logic [NUM_WAKE-1:0] wake_pin,
  input wire logic brownout_out,
  input wire logic monitor_detect,
  input wire logic monitor_reset_enable,
  input wire logic monitor_measure_low,
  input wire logic crystal_selected,
  // system outputs
  output logic core_wakeup,
  output logic backup_storage_clear_low,
  output logic backup_storage_write_block
);

  localparam int unsigned NSYNC = NUM_WAKE + 7;

  // two-stage synchronisers for every asynchronous pin
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  logic [NSYNC-1:0] pins_raw;
  logic slow_prev_q;
  logic rtc_prev_q;
  logic bod_prev_q;
  logic mon_prev_q;

  assign pins_raw = {crystal_selected, monitor_measure_low, monitor_reset_enable,
                     monitor_detect, brownout_out, rtc_output_tick, slow_clock, wake_pin};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  wire [NUM_WAKE-1:0] wake_s = sync2_q[NUM_WAKE-1:0];
  wire slow_s = sync2_q[NUM_WAKE];
  wire rtc_s = sync2_q[NUM_WAKE+1];
  wire bod_s = sync2_q[NUM_WAKE+2];
  wire mon_det_s = sync2_q[NUM_WAKE+3];
  wire mon_rst_en_s = sync2_q[NUM_WAKE+4];
  wire mon_low_s = sync2_q[NUM_WAKE+5];
  wire xtal_s = sync2_q[NUM_WAKE+6];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_prev_q <= 1'b0;
      rtc_prev_q <= 1'b0;
      bod_prev_q <= 1'b0;
      mon_prev_q <= 1'b0;
    end else begin
      slow_prev_q <= slow_s;
      rtc_prev_q <= rtc_s;
      bod_prev_q <= bod_s;
      mon_prev_q <= mon_det_s;
    end
  end

  // slow clock is slower than pclk by far, so one rising edge is one tick
  wire slow_tick = slow_s && !slow_prev_q;
  wire rtc_tick = rtc_s && !rtc_prev_q;
  wire bod_rise = bod_s && !bod_prev_q;
  wire mon_rise = mon_det_s && !mon_prev_q;
  // a detection between slow ticks is held until the next tick, not lost
  logic mon_pend_q;
  wire mon_event = slow_tick && (mon_pend_q || mon_rise);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_pend_q <= 1'b0;
    end else begin
      mon_pend_q <= (mon_pend_q || mon_rise) && !slow_tick;
    end
  end

  // apb decode
  logic [31:0] mode_q;
  logic [31:0] wake_cfg_q;
  logic wp_enable_q;
  status_t status_q;
  status_t status_d;
  logic [31:0] prdata_q;

  wire setup_ph = psel && !penable;
  wire access_ph = psel && penable;
  wire hit_mode = (paddr == WAKE_MODE_ADDR);
  wire hit_cfg = (paddr == WAKE_INPUT_CONFIG_ADDR);
  wire hit_status = (paddr == SUPPLY_EVENT_STATUS_ADDR);
  wire hit_wp = (paddr == SYSCTL_WRITE_PROTECT_ADDR);
  wire mapped = hit_mode || hit_cfg || hit_status || hit_wp;
  wire full_word = (pstrb == 4'hf);
  wire wr_ok = access_ph && pwrite && mapped && full_word;
  wire wr_mode = wr_ok && hit_mode && !wp_enable_q;
  wire wr_cfg = wr_ok && hit_cfg && !wp_enable_q;
  wire key_ok = (pwdata[WP_KEY_LSB +: 24] == WRITE_PROTECT_KEY);
  wire wr_wp = wr_ok && hit_wp && key_ok;
  wire rd_status = access_ph && !pwrite && hit_status;

  assign pready = 1'b1;
  assign pslverr = access_ph && (!mapped || (pwrite && (!full_word || hit_status)));
  assign prdata = prdata_q;

  mode_t mode;
  assign mode.monitor_wake_en = mode_q[MONITOR_WAKE_EN_BIT];
  assign mode.lp_enable_a = mode_q[LP_ENABLE_A_BIT];
  assign mode.lp_enable_b = mode_q[LP_ENABLE_B_BIT];
  assign mode.lp_clear = mode_q[LP_CLEAR_BIT];
  assign mode.wake_debounce_period = mode_q[WAKE_DBC_LSB +: 3];
  assign mode.lowpower_debounce_period = mode_q[LP_DBC_LSB +: 3];

  wire [NUM_WAKE-1:0] wake_en = wake_cfg_q[WAKE_ENABLE_LSB +: NUM_WAKE];
  wire [NUM_WAKE-1:0] wake_pol = wake_cfg_q[WAKE_POLARITY_LSB +: NUM_WAKE];

  // register write and read-data capture; key field never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= WAKE_MODE_RESET;
      wake_cfg_q <= WAKE_INPUT_CONFIG_RESET;
      wp_enable_q <= WRITE_PROTECT_RESET;
    end else begin
      if (wr_mode) begin
        mode_q <= pwdata & 32'h000770e2;
      end
      if (wr_cfg) begin
        wake_cfg_q <= pwdata;
      end
      if (wr_wp) begin
        wp_enable_q <= pwdata[WP_ENABLE_BIT];
      end
    end
  end

  logic [31:0] rd_mux;
  assign rd_mux = hit_mode ? mode_q :
                  hit_cfg ? wake_cfg_q :
                  hit_status ? status_word(status_q) :
                  hit_wp ? {31'h0, wp_enable_q} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
    end else if (setup_ph && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  function automatic logic [31:0] status_word(input status_t s);
    status_word = {s.wake_input_snapshot, 1'b0, s.lp_wake_flag_pin_b, s.lp_wake_flag_pin_a,
                   5'h0, s.slow_clock_source_flag, s.monitor_output_level,
                   s.monitor_detect_flag, s.monitor_reset_flag, s.brownout_event_flag,
                   s.monitor_wake_flag, s.wake_pin_event_flag, 1'b0};
  endfunction : status_word

  // wake-up debounce length from the period code
  logic [15:0] wake_limit;
  always_comb begin
    case (mode.wake_debounce_period)
      3'h0: wake_limit = WAKE_DBC_IMMEDIATE;
      3'h1: wake_limit = WAKE_DBC_3;
      3'h2: wake_limit = WAKE_DBC_32;
      3'h3: wake_limit = WAKE_DBC_512;
      3'h4: wake_limit = DBC_4096[15:0];
      3'h5: wake_limit = DBC_32768[15:0];
      default: wake_limit = DBC_32768[15:0];
    endcase
  end

  wire [NUM_WAKE-1:0] wake_active = ~(wake_s ^ wake_pol);
  wire [NUM_WAKE-1:0] wake_armed = wake_active & wake_en;
  logic [NUM_WAKE-1:0] wake_fire;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_WAKE; gi++) begin : g_wake
      level_debouncer #(.CNT_W(16)) u_dbc (
        .pclk(pclk),
        .presetn(presetn),
        .tick(slow_tick),
        .active(wake_armed[gi]),
        .limit(wake_limit),
        .fire(wake_fire[gi])
      );
    end
  endgenerate

  // low-power debouncers on pins 0 and 1, timed by the rtc tick
  wire lp_on = (mode.lowpower_debounce_period != 3'h0);
  wire [3:0] lp_limit = {1'b0, mode.lowpower_debounce_period} + 4'h1;
  wire [1:0] lp_armed = wake_active[1:0] & {mode.lp_enable_b, mode.lp_enable_a}
                        & {2{lp_on}};
  logic [1:0] lp_fire;

  generate
    for (gi = 0; gi < 2; gi++) begin : g_lp
      level_debouncer #(.CNT_W(4)) u_lp (
        .pclk(pclk),
        .presetn(presetn),
        .tick(rtc_tick),
        .active(lp_armed[gi]),
        .limit(lp_limit),
        .fire(lp_fire[gi])
      );
    end
  endgenerate

  wire pin_wake = |wake_fire;
  wire mon_wake = mon_event && mode.monitor_wake_en;
  wire lp_event = |lp_fire;

  // delayed clear: counts slow ticks after a status read
  logic clr_pend_q;
  logic [1:0] clr_cnt_q;
  logic [31:0] clr_mask_q;
  logic [31:0] kept_q;
  wire clr_now = clr_pend_q && slow_tick && (clr_cnt_q == STATUS_CLEAR_DELAY - 2'h1);

  status_t set_ev;
  always_comb begin
    set_ev = '0;
    set_ev.wake_pin_event_flag = pin_wake;
    set_ev.monitor_wake_flag = mon_wake;
    set_ev.brownout_event_flag = bod_rise;
    set_ev.monitor_reset_flag = mon_event && mon_rst_en_s;
    set_ev.monitor_detect_flag = mon_event;
    set_ev.lp_wake_flag_pin_a = lp_fire[0];
    set_ev.lp_wake_flag_pin_b = lp_fire[1];
    set_ev.wake_input_snapshot = pin_wake ? wake_armed : 16'h0;
  end

  wire [31:0] set_bits = status_word(set_ev);
  // events seen after the read stay out of the clear
  wire [31:0] clr_bits = clr_now ? (clr_mask_q & ~kept_q & ~set_bits) : 32'h0;
  wire [31:0] flags_next = (status_word(status_q) & ~clr_bits) | set_bits;

  always_comb begin
    status_d = '0;
    status_d.wake_pin_event_flag = flags_next[1];
    status_d.monitor_wake_flag = flags_next[2];
    status_d.brownout_event_flag = flags_next[3];
    status_d.monitor_reset_flag = flags_next[4];
    status_d.monitor_detect_flag = flags_next[5];
    status_d.lp_wake_flag_pin_a = flags_next[13];
    status_d.lp_wake_flag_pin_b = flags_next[14];
    status_d.wake_input_snapshot = flags_next[31:16];
    // level bits follow their source rather than latching
    status_d.monitor_output_level = slow_tick ? mon_low_s : status_q.monitor_output_level;
    status_d.slow_clock_source_flag = xtal_s;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_pend_q <= 1'b0;
      clr_cnt_q <= 2'h0;
      clr_mask_q <= 32'h0;
      kept_q <= 32'h0;
    end else if (rd_status) begin
      clr_pend_q <= 1'b1;
      clr_cnt_q <= 2'h0;
      clr_mask_q <= clr_mask_q | prdata_q;
      kept_q <= 32'h0;
    end else if (clr_now) begin
      clr_pend_q <= 1'b0;
      clr_cnt_q <= 2'h0;
      clr_mask_q <= 32'h0;
      kept_q <= 32'h0;
    end else if (clr_pend_q) begin
      if (slow_tick) begin
        clr_cnt_q <= clr_cnt_q + 2'h1;
      end
      kept_q <= kept_q | set_bits;
    end
  end

  // system outputs
  logic wake_q;
  logic bclr_q;
  logic tamper_q;
  wire lp_flags_clear = !status_q.lp_wake_flag_pin_a && !status_q.lp_wake_flag_pin_b;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_q <= 1'b0;
      bclr_q <= 1'b0;
      tamper_q <= 1'b0;
    end else begin
      wake_q <= pin_wake || mon_wake || lp_event;
      bclr_q <= lp_event && mode.lp_clear;
      if (lp_event) begin
        tamper_q <= 1'b1;
      end else if (lp_flags_clear) begin
        tamper_q <= 1'b0;
      end
    end
  end

  assign core_wakeup = wake_q;
  assign backup_storage_clear_low = bclr_q;
  assign backup_storage_write_block = tamper_q;

endmodule : supply_wakeup_status_logic
`default_nettype wire

// >>> hdl/wake_status_pkg.sv
// constants, offsets, field positions and carrier types of the wake-up and status logic
// assumes one 40 MHz register clock; slow clock and rtc tick arrive as pins
package wake_status_pkg;

  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned NUM_WAKE = 16;

  // register byte addresses
  localparam logic [31:0] WAKE_MODE_ADDR = 32'h400e141c;
  localparam logic [31:0] WAKE_INPUT_CONFIG_ADDR = 32'h400e1420;
  localparam logic [31:0] SUPPLY_EVENT_STATUS_ADDR = 32'h400e1424;
  localparam logic [31:0] SYSCTL_WRITE_PROTECT_ADDR = 32'h400e14e4;

  // reset values
  localparam logic [31:0] WAKE_MODE_RESET = 32'h00000000;
  localparam logic [31:0] WAKE_INPUT_CONFIG_RESET = 32'h00000000;
  localparam logic WRITE_PROTECT_RESET = 1'b0;

  // wake_mode fields
  localparam int unsigned MONITOR_WAKE_EN_BIT = 1;
  localparam int unsigned LP_ENABLE_A_BIT = 5;
  localparam int unsigned LP_ENABLE_B_BIT = 6;
  localparam int unsigned LP_CLEAR_BIT = 7;
  localparam int unsigned WAKE_DBC_LSB = 12;
  localparam int unsigned LP_DBC_LSB = 16;

  // wake_input_config fields
  localparam int unsigned WAKE_ENABLE_LSB = 0;
  localparam int unsigned WAKE_POLARITY_LSB = 16;

  // write protect fields
  localparam int unsigned WP_ENABLE_BIT = 0;
  localparam int unsigned WP_KEY_LSB = 8;
  localparam logic [23:0] WRITE_PROTECT_KEY = 24'h525443;

  // debounce lengths in slow clock periods, per period code
  localparam logic [15:0] WAKE_DBC_IMMEDIATE = 16'h0001;
  localparam logic [15:0] WAKE_DBC_3 = 16'h0003;
  localparam logic [15:0] WAKE_DBC_32 = 16'h0020;
  localparam logic [15:0] WAKE_DBC_512 = 16'h0200;
  localparam int unsigned WAKE_DBC_4096 = 4096;
  localparam int unsigned WAKE_DBC_32768 = 32768;

  // delayed clear of status flags, in slow clock cycles
  localparam logic [1:0] STATUS_CLEAR_DELAY = 2'h2;

  // sticky status flags and level bits as laid out in the status word
  typedef struct packed {
    logic [15:0] wake_input_snapshot;
    logic lp_wake_flag_pin_b;
    logic lp_wake_flag_pin_a;
    logic slow_clock_source_flag;
    logic monitor_output_level;
    logic monitor_detect_flag;
    logic monitor_reset_flag;
    logic brownout_event_flag;
    logic monitor_wake_flag;
    logic wake_pin_event_flag;
  } status_t;

  typedef struct packed {
    logic monitor_wake_en;
    logic lp_enable_a;
    logic lp_enable_b;
    logic lp_clear;
    logic [2:0] wake_debounce_period;
    logic [2:0] lowpower_debounce_period;
  } mode_t;

endpackage : wake_status_pkg
